// file: rtl/sgm_pkg.sv
package sgm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 6;
  localparam int NUM_PART = 4;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_FUNC_SEL = 12'h000;
  localparam logic [ADDR_W-1:0] REG_GPIO_DIR = 12'h004;
  localparam logic [ADDR_W-1:0] REG_GPIO_OUT = 12'h008;
  localparam logic [ADDR_W-1:0] REG_GPIO_IN = 12'h00C;
  localparam logic [ADDR_W-1:0] REG_INT_STAT = 12'h010;
  localparam logic [ADDR_W-1:0] REG_INT_MASK = 12'h014;
  localparam logic [ADDR_W-1:0] REG_FAIL_EN = 12'h018;
  localparam logic [ADDR_W-1:0] REG_PART_DRV = 12'h01C;
  localparam logic [ADDR_W-1:0] REG_SYS_STAT = 12'h020;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int FSEL_W = 2;
  localparam int STAT_W = 5;
  localparam int STAT_FAIL_BIT = 4;
  localparam int SYS_FSEL_BIT = 0;
  localparam int SYS_ADDR_LSB = 1;
  localparam int SYS_MCLK_BIT = 3;
  localparam int SLV_SEL_W = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_PINS*FSEL_W-1:0] FUNC_SEL_RST = 12'h000;
  localparam logic [NUM_PINS-1:0] PIN_RST = 6'h00;
  localparam logic [STAT_W-1:0] STAT_RST = 5'h00;
  localparam logic [NUM_PART-1:0] PART_RST = 4'h0;

  // ----------------------------------------------------------------
  // Pin functions and pin roles
  // ----------------------------------------------------------------
  typedef enum logic [FSEL_W-1:0] {
    FN_GPIO,
    FN_ALT1,
    FN_ALT2,
    FN_RSVD
  } sgm_func_type;

  localparam int PIN_FAILOVER = 4;
  localparam int PIN_HOTPLUG = 5;

  // Reference clock frequency select codes.
  localparam logic REFCLK_SEL_100 = 1'h0;
  localparam logic REFCLK_SEL_125 = 1'h1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int MGMT_CLK_HZ = 100_000;
  localparam int MGMT_HALF_CYC = CLK_HZ / (2 * MGMT_CLK_HZ);
  localparam int STRAP_DLY = 3;

endpackage : sgm_pkg

// file: rtl/sgm_mgmt_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sgm_mgmt_if;
  logic busy;
  logic clk_low;
  logic clk_oe;

  modport ctrl (
    output busy,
    input clk_low,
    input clk_oe
  );

  modport gen (
    input busy,
    output clk_low,
    output clk_oe
  );
endinterface : sgm_mgmt_if

`default_nettype wire

// file: rtl/sgm_mgmt_clk.sv
`timescale 1ns/1ps
`default_nettype none

module sgm_mgmt_clk
  import sgm_pkg::*;
#(
  parameter int HALF_CYC = MGMT_HALF_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control side
  sgm_mgmt_if.gen mif
);

  if (HALF_CYC < 1) begin : g_bad_half
    $error("sgm_mgmt_clk: HALF_CYC must be at least one");
  end

  localparam int CNT_W = $clog2(HALF_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYC - 1);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic low_r;
  logic low_nxt;
  logic tick;

  // The line is open drain: driving low is the only active state, so
  // the idle bus is simply released and pulled high by the board.
  always_comb begin
    tick = (cnt_r == CNT_LAST);
    cnt_nxt = cnt_r;
    low_nxt = low_r;
    if (mif.busy || low_r) begin
      cnt_nxt = tick ? '0 : cnt_r + 1'b1;
    end else begin
      cnt_nxt = '0;
    end
    if (tick) begin
      low_nxt = mif.busy ? ~low_r : 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      low_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      low_r <= low_nxt;
    end
  end

  assign mif.clk_low = low_r;
  assign mif.clk_oe = low_r;

  property idle_release_p;
    @(posedge pclk) disable iff (!presetn)
      (!mif.busy && !low_r) |=> !low_r;
  endproperty
  mclk_idle_a: assert property (idle_release_p)
    else $error("management clock moved while idle");

endmodule : sgm_mgmt_clk

`default_nettype wire

// file: rtl/sgm_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none

module sgm_pin_mux
  import sgm_pkg::*;
#(
  parameter int MGMT_HALF = MGMT_HALF_CYC,
  parameter logic [6:0] SLAVE_ADDR_BASE = 7'h70
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // General-purpose pins
  input wire logic [NUM_PINS-1:0] gpio_in,
  output logic [NUM_PINS-1:0] gpio_out,
  output logic [NUM_PINS-1:0] gpio_oe,
  // Internal status sources
  input wire logic port16_linkup,
  input wire logic port16_link_active,
  input wire logic port0_linkup,
  input wire logic port0_link_active,
  input wire logic hotplug_event,
  // Internal results
  output logic [NUM_PART-1:0] partition_reset,
  output logic failover_event,
  // Master management clock pin and its busy request
  input wire logic mgmt_master_busy,
  input wire logic master_mgmt_clk_in,
  output logic master_mgmt_clk_out,
  output logic master_mgmt_clk_oe,
  // Slave management address
  input wire logic [SLV_SEL_W-1:0] slave_mgmt_addr_sel,
  input wire logic [6:0] slave_rx_addr,
  input wire logic slave_rx_addr_valid,
  output logic slave_addr_hit,
  // Reference clock select
  input wire logic refclk_freq_select,
  output logic refclk_is_125
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] pin_s1_r, pin_s2_r, pin_s3_r;
  logic [SLV_SEL_W-1:0] asel_s1_r, asel_s2_r;
  logic fsel_s1_r, fsel_s2_r, mclk_s1_r, mclk_s2_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= '1;
      pin_s2_r <= '1;
      pin_s3_r <= '1;
      asel_s1_r <= '0;
      asel_s2_r <= '0;
      fsel_s1_r <= 1'b0;
      fsel_s2_r <= 1'b0;
      mclk_s1_r <= 1'b1;
      mclk_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= gpio_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      asel_s1_r <= slave_mgmt_addr_sel;
      asel_s2_r <= asel_s1_r;
      fsel_s1_r <= refclk_freq_select;
      fsel_s2_r <= fsel_s1_r;
      mclk_s1_r <= master_mgmt_clk_in;
      mclk_s2_r <= mclk_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [NUM_PINS*FSEL_W-1:0] fsel_r, fsel_nxt;
  logic [NUM_PINS-1:0] dir_r, dir_nxt, dout_r, dout_nxt;
  logic [STAT_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, stat_set;
  logic fail_en_r, fail_en_nxt;
  logic [NUM_PART-1:0] pdrv_r, pdrv_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic ready_r, ready_nxt, err_r, err_nxt, irq_r, irq_nxt;
  logic wr_en, setup, hit;
  logic strap_fsel_r;
  logic [SLV_SEL_W-1:0] strap_addr_r;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && ready_r;

  // The slave answers with no wait state: read data and the error flag are
  // registered in the setup cycle, so both come straight from flip-flops.
  always_comb begin
    fsel_nxt = fsel_r;
    dir_nxt = dir_r;
    dout_nxt = dout_r;
    mask_nxt = mask_r;
    fail_en_nxt = fail_en_r;
    pdrv_nxt = pdrv_r;
    stat_nxt = stat_r;
    rdata_nxt = rdata_r;
    hit = 1'b1;
    ready_nxt = setup;
    err_nxt = 1'b0;
    case (paddr)
      REG_FUNC_SEL: rdata_nxt = DATA_W'(fsel_r);
      REG_GPIO_DIR: rdata_nxt = DATA_W'(dir_r);
      REG_GPIO_OUT: rdata_nxt = DATA_W'(dout_r);
      REG_GPIO_IN: rdata_nxt = DATA_W'(pin_s2_r);
      REG_INT_STAT: rdata_nxt = DATA_W'(stat_r);
      REG_INT_MASK: rdata_nxt = DATA_W'(mask_r);
      REG_FAIL_EN: rdata_nxt = DATA_W'(fail_en_r);
      REG_PART_DRV: rdata_nxt = DATA_W'(pdrv_r);
      REG_SYS_STAT: rdata_nxt = DATA_W'({mclk_s2_r, strap_addr_r, strap_fsel_r});
      default: begin
        rdata_nxt = '0;
        hit = 1'b0;
      end
    endcase
    if (!setup) begin
      rdata_nxt = rdata_r;
    end else begin
      err_nxt = !hit;
    end
    if (wr_en) begin
      case (paddr)
        REG_FUNC_SEL: fsel_nxt = pwdata[NUM_PINS*FSEL_W-1:0];
        REG_GPIO_DIR: dir_nxt = pwdata[NUM_PINS-1:0];
        REG_GPIO_OUT: dout_nxt = pwdata[NUM_PINS-1:0];
        REG_INT_STAT: stat_nxt = stat_r & ~pwdata[STAT_W-1:0];
        REG_INT_MASK: mask_nxt = pwdata[STAT_W-1:0];
        REG_FAIL_EN: fail_en_nxt = pwdata[0];
        REG_PART_DRV: pdrv_nxt = pwdata[NUM_PART-1:0];
        default: ;
      endcase
    end
    // A hardware event in the clearing cycle wins over the clear.
    stat_nxt = stat_nxt | stat_set;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsel_r <= FUNC_SEL_RST;
      dir_r <= PIN_RST;
      dout_r <= PIN_RST;
      stat_r <= STAT_RST;
      mask_r <= STAT_RST;
      fail_en_r <= 1'b0;
      pdrv_r <= PART_RST;
      rdata_r <= '0;
      ready_r <= 1'b0;
      err_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      fsel_r <= fsel_nxt;
      dir_r <= dir_nxt;
      dout_r <= dout_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      fail_en_r <= fail_en_nxt;
      pdrv_r <= pdrv_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      err_r <= err_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Straps captured after reset release
  // ----------------------------------------------------------------
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic strap_fsel_nxt;
  logic [SLV_SEL_W-1:0] strap_addr_nxt;
  logic [6:0] my_addr;
  logic hit_r, hit_nxt, f125_r, f125_nxt;

  // The straps are sampled on each of the first STRAP_DLY edges and then held; the last sample
  // is taken after the synchronisers have filled, so a pin that moves later cannot shift the address under a transfer.
  always_comb begin
    strap_cnt_nxt = strap_cnt_r;
    strap_fsel_nxt = strap_fsel_r;
    strap_addr_nxt = strap_addr_r;
    if (strap_cnt_r != 2'(STRAP_DLY)) begin
      strap_cnt_nxt = strap_cnt_r + 1'b1;
      strap_fsel_nxt = fsel_s2_r;
      strap_addr_nxt = asel_s2_r;
    end
    my_addr = {SLAVE_ADDR_BASE[6:3], strap_addr_r[1], strap_addr_r[0], SLAVE_ADDR_BASE[0]};
    hit_nxt = slave_rx_addr_valid && (slave_rx_addr == my_addr);
    f125_nxt = (strap_fsel_r == REFCLK_SEL_125);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_r <= '0;
      strap_fsel_r <= REFCLK_SEL_100;
      strap_addr_r <= '0;
      hit_r <= 1'b0;
      f125_r <= 1'b0;
    end else begin
      strap_cnt_r <= strap_cnt_nxt;
      strap_fsel_r <= strap_fsel_nxt;
      strap_addr_r <= strap_addr_nxt;
      hit_r <= hit_nxt;
      f125_r <= f125_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin multiplexer
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] alt1_out, alt1_oe, alt2_out, alt2_oe, alt2_ok;
  logic [NUM_PINS-1:0] out_nxt, oe_nxt, out_r, oe_r;
  logic [NUM_PINS-1:0] is_alt1;

  // Pin roles, written active high inside and inverted at the pin.
  always_comb begin
    alt1_out = '0;
    alt1_oe = '0;
    alt2_out = '1;
    alt2_oe = '0;
    alt2_ok = '0;
    alt1_oe[NUM_PART-1:0] = pdrv_r;
    alt1_out[PIN_HOTPLUG] = ~hotplug_event;
    alt1_oe[PIN_HOTPLUG] = 1'b1;
    alt2_out[0] = ~port16_linkup;
    alt2_out[PIN_FAILOVER] = ~port0_linkup;
    alt2_out[1] = ~port16_link_active;
    alt2_out[PIN_HOTPLUG] = ~port0_link_active;
    alt2_ok = 6'h33;
    alt2_oe = alt2_ok;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      sgm_func_type fn;
      assign fn = sgm_func_type'(fsel_r[gi*FSEL_W +: FSEL_W]);
      assign is_alt1[gi] = (fn == FN_ALT1);
      assign out_nxt[gi] = (fn == FN_GPIO) ? dout_r[gi] :
                           (fn == FN_ALT1) ? alt1_out[gi] :
                           (fn == FN_ALT2) ? alt2_out[gi] : 1'b1;
      assign oe_nxt[gi] = (fn == FN_GPIO) ? dir_r[gi] :
                          (fn == FN_ALT1) ? alt1_oe[gi] :
                          (fn == FN_ALT2) ? alt2_oe[gi] : 1'b0;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Partition resets and failover
  // ----------------------------------------------------------------
  logic [NUM_PART-1:0] prst_r, prst_nxt;
  logic fail_r, fail_nxt;

  always_comb begin
    stat_set = '0;
    prst_nxt = is_alt1[NUM_PART-1:0] & (~pin_s2_r[NUM_PART-1:0] | pdrv_r);
    stat_set[NUM_PART-1:0] = prst_nxt & ~prst_r;
    fail_nxt = is_alt1[PIN_FAILOVER] && fail_en_r &&
               (pin_s2_r[PIN_FAILOVER] != pin_s3_r[PIN_FAILOVER]);
    stat_set[STAT_FAIL_BIT] = fail_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= '1;
      oe_r <= PIN_RST;
      prst_r <= PART_RST;
      fail_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      prst_r <= prst_nxt;
      fail_r <= fail_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Master management clock
  // ----------------------------------------------------------------
  sgm_mgmt_if mif ();
  assign mif.busy = mgmt_master_busy;

  sgm_mgmt_clk #(
    .HALF_CYC(MGMT_HALF)
  ) u_mclk (
    .pclk(pclk),
    .presetn(presetn),
    .mif(mif.gen)
  );

  assign prdata = rdata_r;
  assign pready = ready_r;
  assign pslverr = err_r;
  assign irq = irq_r;
  assign gpio_out = out_r;
  assign gpio_oe = oe_r;
  assign partition_reset = prst_r;
  assign failover_event = fail_r;
  assign master_mgmt_clk_out = 1'b0;
  assign master_mgmt_clk_oe = mif.clk_oe;
  assign slave_addr_hit = hit_r;
  assign refclk_is_125 = f125_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence fail_edge_s;
    is_alt1[PIN_FAILOVER] && fail_en_r && $changed(pin_s2_r[PIN_FAILOVER]);
  endsequence
  sequence fail_seen_s;
    ##1 fail_r ##1 stat_r[STAT_FAIL_BIT];
  endsequence

  failover_raise_a: assert property (fail_edge_s |-> fail_seen_s)
    else $error("failover edge did not set the event");
  failover_gate_a: assert property (!fail_en_r |=> !fail_r)
    else $error("failover event while capability disabled");
  reset_defaults_a: assert property ($rose(presetn) |-> oe_r == '0)
    else $error("pin driver enabled out of reset");
  part_reset_a: assert property (
    (is_alt1[2] && !pin_s2_r[2]) |=> prst_r[2] && stat_r[3] == $past(stat_r[3]))
    else $error("partition reset line not honoured");
  linkup_pin_a: assert property (
    (fsel_r[1:0] == 2'(FN_ALT2) && $stable(fsel_r)) |=> out_r[0] == !$past(port16_linkup) && oe_r[0])
    else $error("port 16 link-up pin wrong");
  active_pin_a: assert property (
    (fsel_r[11:10] == 2'(FN_ALT2) && $stable(fsel_r)) |=> out_r[5] == !$past(port0_link_active))
    else $error("port 0 link-active pin wrong");
  hotplug_pin_a: assert property (
    (fsel_r[11:10] == 2'(FN_ALT1) && $stable(fsel_r)) |=> out_r[5] == !$past(hotplug_event) && oe_r[5])
    else $error("hot-plug event pin wrong");
  failover_in_a: assert property (
    (fsel_r[9:8] == 2'(FN_ALT1) && $stable(fsel_r)) |=> !oe_r[PIN_FAILOVER])
    else $error("failover input driven");
  addr_hit_a: assert property (
    (slave_rx_addr_valid && slave_rx_addr != my_addr) |=> !hit_r)
    else $error("slave answered a foreign address");
  freq_code_a: assert property (
    (strap_cnt_r == 2'(STRAP_DLY)) |=> refclk_is_125 == ($past(strap_fsel_r) == REFCLK_SEL_125))
    else $error("reference frequency code wrong");
  irq_level_a: assert property (irq_r == (|(stat_r & mask_r)))
    else $error("interrupt not raised");

endmodule : sgm_pin_mux

`default_nettype wire

// file: verif/sgm_board_model.sv
`timescale 1ns/1ps
`default_nettype none

module sgm_board_model
  import sgm_pkg::*;
(
  // Device side
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic [NUM_PINS-1:0] gpio_oe,
  input wire logic master_mgmt_clk_oe,
  // Board drivers
  input wire logic [NUM_PINS-1:0] brd_en,
  input wire logic [NUM_PINS-1:0] brd_val,
  // Resolved pin levels
  output logic [NUM_PINS-1:0] gpio_in,
  output logic master_mgmt_clk_in
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // Every line is pulled up, so a released reset line reads as not asserted.
  // idle high lines
  assign gpio_in = (gpio_out | ~gpio_oe) & (brd_val | ~brd_en);
  assign master_mgmt_clk_in = ~master_mgmt_clk_oe;
endmodule : sgm_board_model

`default_nettype wire

// file: verif/switch_gpio_alt_function_mux_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module switch_gpio_alt_function_mux_tb_top;
  import sgm_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [6:0] BASE = 7'h70;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, irq, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [NUM_PINS-1:0] gpio_in, gpio_out, gpio_oe, brd_en, brd_val;
  logic port16_linkup, port16_link_active, port0_linkup, port0_link_active;
  logic hotplug_event, failover_event, mgmt_master_busy, err;
  logic master_mgmt_clk_in, master_mgmt_clk_out, master_mgmt_clk_oe;
  logic [NUM_PART-1:0] partition_reset;
  logic [SLV_SEL_W-1:0] slave_mgmt_addr_sel;
  logic [6:0] slave_rx_addr, a, mine;
  logic slave_rx_addr_valid, slave_addr_hit, refclk_freq_select, refclk_is_125;
  logic [31:0] lfsr = 32'hE737;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_fo = 0;
  int n_clk = 0;
  int n0;

  always #5 pclk = ~pclk;

  sgm_pin_mux #(.MGMT_HALF(4), .SLAVE_ADDR_BASE(BASE)) dut_u (.*);
  sgm_board_model brd_u (.*);

  always @(posedge pclk) begin
    if (failover_event === 1'b1)
      n_fo <= n_fo + 1;
  end
  always @(master_mgmt_clk_oe) n_clk++;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // One idle edge after each transfer keeps psel from being set twice in a step.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic do_reset(input logic fs);
    @(posedge pclk);
    presetn <= 1'b0;
    refclk_freq_select <= fs;
    cyc(8);
    presetn <= 1'b1;
    cyc(6);
  endtask : do_reset

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, brd_en, brd_val} = '0;
    {port16_linkup, port16_link_active, port0_linkup, port0_link_active} = '0;
    {hotplug_event, mgmt_master_busy, slave_rx_addr, slave_rx_addr_valid} = '0;
    refclk_freq_select = 1'b0;
    lfsr = nxt(lfsr);
    slave_mgmt_addr_sel = lfsr[1:0];
    for (int f = 0; f < 2; f++) begin
      do_reset(f[0]);
      chk("refclk", f, refclk_is_125);
      chk("oe_rst", 0, gpio_oe);
      apb(0, REG_SYS_STAT, 0);
      chk("sys", {28'h0, 1'b1, slave_mgmt_addr_sel, f[0]}, rd);
      apb(0, REG_FUNC_SEL, 0);
      chk("fsel_rst", FUNC_SEL_RST, rd);
      apb(0, 12'h0FC, 0);
      chk("unmapped", 1, err);
    end
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      apb(1, REG_GPIO_DIR, lfsr[5:0]);
      apb(1, REG_GPIO_OUT, lfsr[13:8]);
      brd_en <= ~lfsr[5:0];
      brd_val <= lfsr[21:16];
      cyc(4);
      chk("gpio_oe", lfsr[5:0], gpio_oe);
      chk("gpio_out", lfsr[13:8] & lfsr[5:0], gpio_out & gpio_oe);
      apb(0, REG_GPIO_IN, 0);
      chk("gpio_in", (lfsr[13:8] & lfsr[5:0]) | (lfsr[21:16] & ~lfsr[5:0]), rd);
    end
    brd_en <= 6'h00;
    apb(1, REG_GPIO_DIR, 0);
    $display("test gpio done");
    apb(1, REG_FUNC_SEL, 32'hAAA);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      {port16_linkup, port16_link_active, port0_linkup, port0_link_active} <= lfsr[3:0];
      cyc(3);
      chk("alt2_oe", 6'h33, gpio_oe);
      chk("alt2_out", {~lfsr[0], ~lfsr[1], 2'b00, ~lfsr[2], ~lfsr[3]} & 6'h33,
          gpio_out & 6'h33);
    end
    apb(1, REG_FUNC_SEL, 32'h400);
    for (int v = 0; v < 2; v++) begin
      hotplug_event <= v[0];
      cyc(3);
      chk("hp_pin", {~v[0], 5'h00}, {gpio_out[5] & gpio_oe[5], 5'h00});
    end
    $display("test alt out done");
    apb(1, REG_FUNC_SEL, 32'h055);
    apb(1, REG_INT_MASK, 32'h1F);
    brd_val <= 6'h00;
    for (int i = 0; i < 4; i++) begin
      brd_en <= 6'(1 << i);
      cyc(6);
      chk("part", 1 << i, partition_reset);
      chk("irq", 1, irq);
      apb(0, REG_INT_STAT, 0);
      chk("stat", 1 << i, rd);
      brd_en <= 6'h00;
      cyc(6);
      chk("part_off", 0, partition_reset);
      apb(1, REG_INT_STAT, 1 << i);
      cyc(2);
      chk("irq_clr", 0, irq);
    end
    apb(1, REG_PART_DRV, 32'h4);
    cyc(6);
    chk("drv", 32'h104, {partition_reset, 2'b00, gpio_oe[3:0] & ~gpio_out[3:0]});
    apb(1, REG_PART_DRV, 0);
    cyc(6);
    apb(1, REG_INT_STAT, 32'h1F);
    $display("test partition done");
    apb(1, REG_FUNC_SEL, 32'h100);
    brd_en <= 6'h10;
    brd_val <= 6'h10;
    for (int e = 0; e < 2; e++) begin
      apb(1, REG_FAIL_EN, e);
      cyc(6);
      n0 = n_fo;
      repeat (2) begin
        brd_val <= brd_val ^ 6'h10;
        cyc(8);
      end
      chk("fo_cnt", 2 * e, n_fo - n0);
      apb(0, REG_INT_STAT, 0);
      chk("fo_stat", e << 4, rd);
      apb(1, REG_INT_STAT, 32'h10);
    end
    $display("test failover done");
    for (int b = 0; b < 3; b++) begin
      mgmt_master_busy <= (b == 1);
      cyc(20);
      n0 = n_clk;
      cyc(40);
      chk("mclk", b == 1, (b == 1) ? (n_clk - n0 inside {[9:11]}) : (n_clk != n0));
    end
    chk("mclk_oe", 0, master_mgmt_clk_oe);
    chk("mclk_out", 0, master_mgmt_clk_out);
    $display("test mgmt clock done");
    mine = {BASE[6:3], slave_mgmt_addr_sel, BASE[0]};
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      a = (i < 4) ? {BASE[6:3], i[1:0], BASE[0]} : lfsr[6:0];
      slave_rx_addr <= a;
      slave_rx_addr_valid <= 1'b1;
      @(posedge pclk);
      slave_rx_addr_valid <= 1'b0;
      @(posedge pclk);
      chk("hit", a == mine, slave_addr_hit);
    end
    $display("test slave address done");
    results();
  end
endmodule : switch_gpio_alt_function_mux_tb_top

`default_nettype wire
